/* File: logic/reset_seq_pkg.sv */
// Constants, types and rule overview for the reset sequencer
// Overview of operation
// - Power-on or brown-out is cold; clock source comes from boot select field.
// - All other resets are warm and keep the current oscillator selection bits.
// - Power-on holds reset until supply is good plus the power-on delay.
// - Brown-out holds reset until supply is good plus the brown-out delay.
// - Power-up timer follows brown-out; its end releases reset and starts oscillator.
// - Three-bit select gives eight power-up delays from 0 to 128 ms.
// - Brown-out plus power-up delay restarts whenever supply rises above trip.
// - Clock-ready wait depends on oscillator mode: start-up, counter, lock.
// - Crystal modes count 1024 oscillator periods before the clock is ready.
// - With the clock ready, execution starts at program address zero.
// - Clock-fail monitor, if enabled, starts after clock ready plus its delay.
// - Power-on sets the power-on flag, bit 0 of reset control.
// - Brown-out sets the brown-out flag, bit 1 of reset control.
// - Reset pin is driven low externally; only pulses over minimum width reset.
// - Reset from the pin sets the external-reset flag.
// - Software reset asserts system reset without touching the clock.
// - Software reset releases on the next cycle, then vector fetch begins.
// - Software reset sets the software-reset flag, bit 6.
// - System reset is active whenever any reset source is active.
// - Power-on clears all flags but power-on; software may write any flag.
// - Watchdog time-out resets asynchronously, keeps clock; in sleep it wakes.
package reset_seq_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS      = 20;
  localparam int POWER_ON_DELAY_US  = 10;
  localparam int BROWNOUT_DELAY_US  = 10;
  localparam int PIN_MIN_WIDTH_NS   = 2000;
  localparam int FRC_START_NS       = 1100;
  localparam int LOW_POWER_RC_OSC_START_US      = 70;
  localparam int PRI_START_US       = 10;
  localparam int PLL_LOCK_US        = 1500;
  localparam int MONITOR_DELAY_US   = 20;
  localparam int MS_NS              = 1000000;
  localparam int POWER_ON_CYCLES    = (POWER_ON_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BROWNOUT_CYCLES    = (BROWNOUT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_MIN_CYCLES     = (PIN_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRC_START_CYCLES   = FRC_START_NS / CLK_PERIOD_NS;
  localparam int LOW_POWER_RC_OSC_START_CYCLES  = LOW_POWER_RC_OSC_START_US * 1000 / CLK_PERIOD_NS;
  localparam int PRI_START_CYCLES   = PRI_START_US * 1000 / CLK_PERIOD_NS;
  localparam int PLL_LOCK_CYCLES    = PLL_LOCK_US * 1000 / CLK_PERIOD_NS;
  localparam int MONITOR_CYCLES     = (MONITOR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_CYCLES          = MS_NS / CLK_PERIOD_NS;
  localparam int OST_PERIODS        = 1024;
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [5:0]  IDX_RESET_CTRL = 6'h00;
  localparam logic [5:0]  IDX_OSC_CTRL   = 6'h01;
  localparam logic [5:0]  IDX_STATUS     = 6'h02;
  localparam logic [5:0]  IDX_CONTROL    = 6'h03;
  localparam int          RC_POR_BIT     = 0;
  localparam int          RC_BOR_BIT     = 1;
  localparam int          RC_WATCHDOG_TIMEOUT_FLAG_BIT    = 4;
  localparam int          RC_SWR_BIT     = 6;
  localparam int          RC_EXT_BIT     = 7;
  localparam logic [15:0] RC_MASK        = 16'h00d3;
  localparam logic [15:0] RC_RESET       = 16'h0001;
  localparam int          OSC_CUR_LSB    = 12;
  localparam int          CTRL_SOFT_BIT  = 0;
  localparam int          CTRL_MON_BIT   = 1;
  localparam logic [2:0]  OSC_CUR_RESET  = 3'h0;
  // ----------------------------------------
  // Oscillator codes
  // ----------------------------------------
  localparam logic [2:0]  OSC_FRC        = 3'h0;
  localparam logic [2:0]  OSC_FRC_PLL    = 3'h1;
  localparam logic [2:0]  OSC_PRI        = 3'h2;
  localparam logic [2:0]  OSC_PRI_PLL    = 3'h3;
  localparam logic [2:0]  OSC_LOW_POWER_RC_OSC       = 3'h5;
  typedef enum logic [1:0] {PRI_EC, PRI_XT, PRI_HS} pri_mode_t;
  typedef struct packed {
    pri_mode_t  primary_mode;
    logic [2:0] boot_osc_select;
  } osc_config_word_t;
  typedef struct packed {
    logic [2:0] powerup_delay_select;
  } power_config_word_t;
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;
endpackage

/* File: logic/reset_sequencer_status.sv */
// Reset source combiner, cold/warm sequencer and reset cause flags
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ns
module reset_sequencer_status #(
  parameter int unsigned CYCLES_PER_MS = reset_seq_pkg::MS_CYCLES,
  parameter int unsigned LOCK_CYCLES   = reset_seq_pkg::PLL_LOCK_CYCLES,
  parameter int unsigned PIN_CYCLES    = reset_seq_pkg::PIN_MIN_CYCLES,
  parameter int unsigned OST_COUNT     = reset_seq_pkg::OST_PERIODS
) (
  input  wire  logic                               ref_clk,
  input  wire  logic                               rst,
  input  wire  reset_seq_pkg::ahb_req_t            ahb_req,
  output       reset_seq_pkg::ahb_rsp_t            ahb_rsp,
  input  wire  logic                               por_supply_low,
  input  wire  logic                               bor_supply_low,
  input  wire  logic                               external_reset_pin_n,
  input  wire  logic                               osc_clk_tick,
  input  wire  logic                               watchdog_timeout,
  input  wire  logic                               cpu_sleeping,
  input  wire  reset_seq_pkg::osc_config_word_t    osc_config_word,
  input  wire  reset_seq_pkg::power_config_word_t  power_config_word,
  output       logic                               system_reset,
  output       logic                               osc_enable,
  output       logic                               clock_ready,
  output       logic                               fetch_start,
  output       logic [23:0]                        reset_vector,
  output       logic [2:0]                         current_osc_select,
  output       logic                               clock_fail_monitor,
  output       logic                               wake_event
);
  import reset_seq_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    SEQ_POR, SEQ_BOR, SEQ_POWERUP_TIMER, SEQ_OSCD, SEQ_OST, SEQ_LOCK, SEQ_RUN, SEQ_WARM, SEQ_SOFT
  } seq_state_t;

  typedef struct packed {
    seq_state_t  state;
    logic [31:0] count;
    logic [10:0] ticks;
    logic [15:0] pin_cnt;
    logic [3:0]  sy1;
    logic [3:0]  sy2;
    logic [3:0]  sy3;
    logic [3:0]  stable;
    logic        tick_prev;
    logic        cold;
    logic [2:0]  osc_cur;
    logic [15:0] reset_control_reg;
    logic        mon_en;
    logic        mon_active;
    logic        fetch;
    logic        wake;
    logic        a_valid;
    logic        a_write;
    logic [5:0]  a_idx;
    logic [31:0] rdata;
  } state_t;

  localparam logic [3:0] SYNC_IDLE = 4'h4;

  state_t state_reg;
  state_t state_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] powerup_timer_cycles(input logic [2:0] sel);
    powerup_timer_cycles = (sel == 3'h0) ? 32'h0 : ((32'h1 << sel) * 32'(CYCLES_PER_MS));
  endfunction

  function automatic logic [31:0] oscd_cycles(input logic [2:0] osc, input pri_mode_t pm);
    if (osc == OSC_LOW_POWER_RC_OSC)
    begin
      oscd_cycles = 32'(LOW_POWER_RC_OSC_START_CYCLES);
    end
    else if (osc == OSC_PRI || osc == OSC_PRI_PLL)
    begin
      oscd_cycles = (pm == PRI_EC) ? 32'h0 : 32'(PRI_START_CYCLES);
    end
    else
    begin
      oscd_cycles = 32'(FRC_START_CYCLES);
    end
  endfunction

  function automatic logic uses_ost(input logic [2:0] osc, input pri_mode_t pm);
    uses_ost = (osc == OSC_PRI || osc == OSC_PRI_PLL) && (pm != PRI_EC);
  endfunction

  function automatic logic uses_pll(input logic [2:0] osc);
    uses_pll = (osc == OSC_FRC_PLL) || (osc == OSC_PRI_PLL);
  endfunction

  function automatic logic [31:0] read_word(input state_t s, input logic [5:0] idx);
    read_word = 32'h0;
    if (idx == IDX_RESET_CTRL)
    begin
      read_word[15:0] = s.reset_control_reg;
    end
    else if (idx == IDX_OSC_CTRL)
    begin
      read_word[OSC_CUR_LSB +: 3] = s.osc_cur;
    end
    else if (idx == IDX_STATUS)
    begin
      read_word[3:0] = s.state;
      read_word[4]   = s.state == SEQ_RUN;
      read_word[5]   = s.mon_active;
      read_word[6]   = s.cold;
    end
    else if (idx == IDX_CONTROL)
    begin
      read_word[CTRL_MON_BIT] = s.mon_en;
    end
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic por_low;
  logic bor_low;
  logic pin_low;
  logic tick_rise;
  logic pin_active;
  logic soft_req;
  logic wdt_reset;

  always_comb
  begin
    state_next = state_reg;
    // Input synchronisers; a change counts when stages two and three agree
    state_next.sy1 = {osc_clk_tick, external_reset_pin_n, bor_supply_low, por_supply_low};
    state_next.sy2 = state_reg.sy1;
    state_next.sy3 = state_reg.sy2;
    state_next.stable = (~(state_reg.sy2 ^ state_reg.sy3) & state_reg.sy3)
                      | ((state_reg.sy2 ^ state_reg.sy3) & state_reg.stable);
    por_low   = state_reg.stable[0];
    bor_low   = state_reg.stable[1];
    pin_low   = ~state_reg.stable[2];
    tick_rise = state_reg.stable[3] & ~state_reg.tick_prev;
    state_next.tick_prev = state_reg.stable[3];

    // Glitch filter: only a low lasting the minimum width counts
    if (pin_low)
    begin
      if (state_reg.pin_cnt < 16'(PIN_CYCLES))
      begin
        state_next.pin_cnt = state_reg.pin_cnt + 16'h1;
      end
    end
    else
    begin
      state_next.pin_cnt = 16'h0;
    end
    pin_active = state_reg.pin_cnt >= 16'(PIN_CYCLES);
    wdt_reset  = watchdog_timeout & ~cpu_sleeping;

    state_next.count = state_reg.count + 32'h1;
    state_next.fetch = 1'b0;
    state_next.wake  = 1'b0;

    // Bus: address phase captured, data phase applied one edge later
    soft_req = 1'b0;
    state_next.a_valid = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
    if (state_next.a_valid)
    begin
      state_next.a_write = ahb_req.hwrite;
      state_next.a_idx   = ahb_req.haddr[7:2];
      state_next.rdata   = (ahb_req.hwrite || ahb_req.haddr[31:8] != 24'h0) ? 32'h0
                         : read_word(state_reg, ahb_req.haddr[7:2]);
    end
    if (state_reg.a_valid && state_reg.a_write)
    begin
      if (state_reg.a_idx == IDX_RESET_CTRL)
      begin
        state_next.reset_control_reg = ahb_req.hwdata[15:0] & RC_MASK;
      end
      else if (state_reg.a_idx == IDX_CONTROL)
      begin
        soft_req = ahb_req.hwdata[CTRL_SOFT_BIT];
        state_next.mon_en = ahb_req.hwdata[CTRL_MON_BIT];
      end
    end

    // Sequencer
    unique case (state_reg.state)
      SEQ_POR:
      begin
        if (state_reg.count >= 32'(POWER_ON_CYCLES))
        begin
          state_next.state = SEQ_BOR;
          state_next.count = 32'h0;
        end
      end
      SEQ_BOR:
      begin
        if (state_reg.count >= 32'(BROWNOUT_CYCLES))
        begin
          state_next.state = SEQ_POWERUP_TIMER;
          state_next.count = 32'h0;
        end
      end
      SEQ_POWERUP_TIMER:
      begin
        if (state_reg.count >= powerup_timer_cycles(power_config_word.powerup_delay_select))
        begin
          state_next.state = SEQ_OSCD;
          state_next.count = 32'h0;
          if (state_reg.cold)
          begin
            state_next.osc_cur = osc_config_word.boot_osc_select;
          end
        end
      end
      SEQ_OSCD:
      begin
        if (state_reg.count >= oscd_cycles(state_reg.osc_cur, osc_config_word.primary_mode))
        begin
          state_next.count = 32'h0;
          state_next.ticks = 11'h0;
          if (uses_ost(state_reg.osc_cur, osc_config_word.primary_mode))
          begin
            state_next.state = SEQ_OST;
          end
          else if (uses_pll(state_reg.osc_cur))
          begin
            state_next.state = SEQ_LOCK;
          end
          else
          begin
            state_next.state = SEQ_RUN;
            state_next.fetch = 1'b1;
          end
        end
      end
      SEQ_OST:
      begin
        if (tick_rise)
        begin
          state_next.ticks = state_reg.ticks + 11'h1;
        end
        if (state_reg.ticks >= 11'(OST_COUNT))
        begin
          state_next.count = 32'h0;
          if (uses_pll(state_reg.osc_cur))
          begin
            state_next.state = SEQ_LOCK;
          end
          else
          begin
            state_next.state = SEQ_RUN;
            state_next.fetch = 1'b1;
          end
        end
      end
      SEQ_LOCK:
      begin
        if (state_reg.count >= 32'(LOCK_CYCLES))
        begin
          state_next.state = SEQ_RUN;
          state_next.count = 32'h0;
          state_next.fetch = 1'b1;
        end
      end
      SEQ_RUN:
      begin
        state_next.cold = 1'b0;
        // Saturate so the monitor never drops out on wrap
        if (state_reg.count >= 32'(MONITOR_CYCLES))
        begin
          state_next.count = state_reg.count;
          state_next.mon_active = state_reg.mon_en;
        end
        if (!state_reg.mon_en)
        begin
          state_next.mon_active = 1'b0;
        end
      end
      SEQ_WARM, SEQ_SOFT:
      begin
        // Clock is kept, so release goes straight to the vector fetch
        state_next.state = SEQ_RUN;
        state_next.count = 32'h0;
        state_next.fetch = 1'b1;
      end
    endcase

    // Reset sources, highest first; flag sets come after the bus write
    if (por_low)
    begin
      state_next.state = SEQ_POR;
      state_next.count = 32'h0;
      state_next.cold  = 1'b1;
      state_next.reset_control_reg  = RC_RESET;
      state_next.fetch = 1'b0;
      state_next.mon_active = 1'b0;
    end
    else if (bor_low)
    begin
      // Any dip restarts the whole brown-out plus power-up wait
      if (state_reg.state != SEQ_POR)
      begin
        state_next.state = SEQ_BOR;
        state_next.count = 32'h0;
        state_next.reset_control_reg[RC_BOR_BIT] = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count;
      end
      state_next.cold  = 1'b1;
      state_next.fetch = 1'b0;
      state_next.mon_active = 1'b0;
    end
    else if (state_reg.state == SEQ_POR || state_reg.state == SEQ_BOR
          || state_reg.state == SEQ_POWERUP_TIMER)
    begin
      // During the cold sequence only the pin adds its flag; watchdog and software requests set no flag
      if (pin_active)
      begin
        state_next.reset_control_reg[RC_EXT_BIT] = 1'b1;
      end
    end
    else if (pin_active)
    begin
      state_next.state = SEQ_WARM;
      state_next.reset_control_reg[RC_EXT_BIT] = 1'b1;
      state_next.fetch = 1'b0;
      state_next.mon_active = 1'b0;
    end
    else if (wdt_reset)
    begin
      state_next.state = SEQ_WARM;
      state_next.reset_control_reg[RC_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
      state_next.fetch = 1'b0;
      state_next.mon_active = 1'b0;
    end
    else if (soft_req)
    begin
      state_next.state = SEQ_SOFT;
      state_next.reset_control_reg[RC_SWR_BIT] = 1'b1;
      state_next.fetch = 1'b0;
      state_next.mon_active = 1'b0;
    end
    if (watchdog_timeout && cpu_sleeping && !por_low && !bor_low)
    begin
      state_next.wake = 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg.state      <= SEQ_POR;
      state_reg.count      <= 32'h0;
      state_reg.ticks      <= 11'h0;
      state_reg.pin_cnt    <= 16'h0;
      state_reg.sy1        <= SYNC_IDLE;
      state_reg.sy2        <= SYNC_IDLE;
      state_reg.sy3        <= SYNC_IDLE;
      state_reg.stable     <= SYNC_IDLE;
      state_reg.tick_prev  <= 1'b0;
      state_reg.cold       <= 1'b1;
      state_reg.osc_cur    <= OSC_CUR_RESET;
      state_reg.reset_control_reg       <= RC_RESET;
      state_reg.mon_en     <= 1'b0;
      state_reg.mon_active <= 1'b0;
      state_reg.fetch      <= 1'b0;
      state_reg.wake       <= 1'b0;
      state_reg.a_valid    <= 1'b0;
      state_reg.a_write    <= 1'b0;
      state_reg.a_idx      <= 6'h0;
      state_reg.rdata      <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Watchdog and pin paths bypass the state so reset rises in the same cycle
  assign system_reset = (state_reg.state == SEQ_POR) || (state_reg.state == SEQ_BOR)
                     || (state_reg.state == SEQ_POWERUP_TIMER) || (state_reg.state == SEQ_WARM)
                     || (state_reg.state == SEQ_SOFT) || pin_active || wdt_reset;
  assign osc_enable         = ~((state_reg.state == SEQ_POR) || (state_reg.state == SEQ_BOR)
                             || (state_reg.state == SEQ_POWERUP_TIMER));
  assign clock_ready        = state_reg.state == SEQ_RUN;
  assign fetch_start        = state_reg.fetch;
  assign reset_vector       = RESET_VECTOR;
  assign current_osc_select = state_reg.osc_cur;
  assign clock_fail_monitor = state_reg.mon_active;
  assign wake_event         = state_reg.wake;
  assign ahb_rsp.hrdata     = state_reg.rdata;
  assign ahb_rsp.hreadyout  = 1'b1;
  assign ahb_rsp.hresp      = 1'b0;
endmodule // reset_sequencer_status

/* File: tb/reset_seq_monitor.sv */
// Port-level assertion checker for the reset sequencer
`timescale 1ns/1ns
module reset_seq_monitor
  import reset_seq_pkg::*;
#(
  parameter int unsigned PIN_CYCLES = 100
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire ahb_rsp_t    ahb_rsp,
  input wire logic        bor_supply_low,
  input wire logic        external_reset_pin_n,
  input wire logic        watchdog_timeout,
  input wire logic        cpu_sleeping,
  input wire logic        system_reset,
  input wire logic        osc_enable,
  input wire logic        clock_ready,
  input wire logic        fetch_start,
  input wire logic [23:0] reset_vector,
  input wire logic [2:0]  current_osc_select,
  input wire logic        clock_fail_monitor,
  input wire logic        wake_event
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  int unsigned low_cnt;
  int unsigned rdy_cnt;
  // Run lengths of pin low and clock ready
  always_ff @(posedge ref_clk)
  begin
    low_cnt <= external_reset_pin_n ? 0 : low_cnt + 1;
    rdy_cnt <= clock_ready ? rdy_cnt + 1 : 0;
  end
  property p_bor_reset;
    $rose(bor_supply_low) |-> ##[1:6] system_reset;
  endproperty
  property p_wdt_reset;
    watchdog_timeout && !cpu_sleeping |-> system_reset;
  endproperty
  property p_wdt_wake;
    watchdog_timeout && cpu_sleeping && clock_ready |-> !system_reset ##1 wake_event;
  endproperty
  property p_wake_cause;
    wake_event |-> $past(watchdog_timeout && cpu_sleeping);
  endproperty
  property p_fetch;
    fetch_start |-> clock_ready && reset_vector == 24'h000000;
  endproperty
  property p_monitor;
    $rose(clock_fail_monitor) |-> rdy_cnt >= 998;
  endproperty
  property p_osc_keep;
    !$stable(current_osc_select) |-> $rose(osc_enable);
  endproperty
  // Short pin pulses must be filtered out
  property p_pin_filter;
    clock_ready && !watchdog_timeout && low_cnt < PIN_CYCLES |-> !system_reset;
  endproperty
  property p_bus_okay;
    ahb_rsp.hreadyout && !ahb_rsp.hresp;
  endproperty
  a_bor_reset: assert property (p_bor_reset)
    else $error("no reset after brown-out");
  a_wdt_reset: assert property (p_wdt_reset)
    else $error("watchdog did not reset");
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("sleeping watchdog did not wake");
  a_wake_cause: assert property (p_wake_cause)
    else $error("wake without cause");
  a_fetch: assert property (p_fetch)
    else $error("fetch without ready clock");
  a_monitor: assert property (p_monitor)
    else $error("monitor started early");
  a_osc_keep: assert property (p_osc_keep)
    else $error("clock source changed on warm reset");
  a_pin_filter: assert property (p_pin_filter)
    else $error("short pin pulse caused reset");
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus not ready or error");
  c_fetch: cover property (fetch_start);
  c_wake: cover property (wake_event);
  c_monitor: cover property ($rose(clock_fail_monitor));
endmodule // reset_seq_monitor

bind reset_sequencer_status reset_seq_monitor #(.PIN_CYCLES(PIN_CYCLES)) u_mon (
  .ref_clk, .rst, .ahb_rsp, .bor_supply_low, .external_reset_pin_n, .watchdog_timeout,
  .cpu_sleeping, .system_reset, .osc_enable, .clock_ready, .fetch_start, .reset_vector,
  .current_osc_select, .clock_fail_monitor, .wake_event);

/* File: tb/ext_supervisor.sv */
// Model of the outside supervisor that pulls the reset pin low
`timescale 1ns/1ns
module ext_supervisor (
  input  wire logic       ref_clk,
  input  wire logic       start,
  input  wire logic [7:0] hold,
  output      logic       pin_n
);
  logic [7:0] left = 8'h00;
  // No pull-up on the pin, so it is always driven
  assign pin_n = (left == 8'h00);
  always @(posedge ref_clk)
    if (start)
      left <= hold;
    else if (left != 8'h00)
      left <= left - 8'h01;
endmodule // ext_supervisor

/* File: tb/tb.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/1ns
module tb;
  import reset_seq_pkg::*;
  typedef struct {logic [2:0] osc; pri_mode_t md; logic [2:0] pw; int lo; int hi;} row_t;
  logic ref_clk = 0, slp = 0, sv_go = 0;
  // Pulsed sources: 0 reset, 1 watchdog, 2 brown-out, 3 power-on
  logic [3:0] src = 4'h1;
  wire rst = src[0];
  wire wdt = src[1];
  wire bor_lo = src[2];
  wire por_lo = src[3];
  logic [7:0] sv_hold = 8'h00;
  logic [3:0] tdiv = 4'h0;
  logic pin_n, sys, oen, rdy, fst, mon, wake;
  logic [23:0] vec;
  logic [2:0] cos;
  logic [31:0] rd;
  ahb_req_t req = '{hready: 1'b1, default: '0};
  ahb_rsp_t rsp;
  osc_config_word_t ocw = '0;
  power_config_word_t pcw = '0;
  int n_fail = 0, total_checks = 0, cyc = 0, n, p;
  // Clock wait after osc enable, per boot source and mode
  row_t rows[6] = '{'{3'h0, PRI_EC, 3'h0, 54, 58}, '{3'h1, PRI_EC, 3'h1, 74, 78},
    '{3'h2, PRI_EC, 3'h2, 0, 3}, '{3'h2, PRI_XT, 3'h3, 520, 545},
    '{3'h3, PRI_HS, 3'h7, 540, 565}, '{3'h5, PRI_EC, 3'h4, 3499, 3503}};

  reset_sequencer_status #(.CYCLES_PER_MS(10), .LOCK_CYCLES(20), .PIN_CYCLES(4),
    .OST_COUNT(8)) u_dut (.ref_clk, .rst, .ahb_req(req), .ahb_rsp(rsp),
    .por_supply_low(por_lo), .bor_supply_low(bor_lo), .external_reset_pin_n(pin_n),
    .osc_clk_tick(tdiv[1]), .watchdog_timeout(wdt), .cpu_sleeping(slp),
    .osc_config_word(ocw), .power_config_word(pcw), .system_reset(sys), .osc_enable(oen),
    .clock_ready(rdy), .fetch_start(fst), .reset_vector(vec), .current_osc_select(cos),
    .clock_fail_monitor(mon), .wake_event(wake));
  ext_supervisor u_sup (.ref_clk, .start(sv_go), .hold(sv_hold), .pin_n);

  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tdiv <= tdiv + 4'h1;

  task automatic report_and_stop();
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(string nm, int lo, int hi, int g);
    total_checks++;
    if (g < lo || g > hi)
    begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= 2'b10;
    req.hwrite <= w;
    req.hsize <= 3'b010;
    do @(posedge ref_clk); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge ref_clk); while (rsp.hreadyout !== 1'b1);
    r = rsp.hrdata;
  endtask
  function automatic logic pick(int k);
    logic [5:0] s;
    s = {wake, mon, fst, sys, rdy, oen};
    return s[k];
  endfunction
  // Bounded wait on one output; n holds the cycles taken
  task automatic wait_on(int k, logic v, int lim);
    n = 0;
    #1;
    while (pick(k) !== v && n < lim)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= lim)
      chk("wait", 32'h1, 32'h0);
  endtask
  task automatic pulse(int k, int len);
    @(posedge ref_clk);
    src[k] <= 1'b1;
    repeat (len) @(posedge ref_clk);
    src[k] <= 1'b0;
  endtask
  task automatic pin_pulse(logic [7:0] len);
    @(posedge ref_clk);
    sv_hold <= len;
    sv_go <= 1'b1;
    @(posedge ref_clk);
    sv_go <= 1'b0;
  endtask

  initial
  begin
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      ocw.boot_osc_select <= rows[i].osc;
      ocw.primary_mode <= rows[i].md;
      pcw.powerup_delay_select <= rows[i].pw;
      pulse(0, 3);
      p = rows[i].pw == 3'h0 ? 0 : (1 << rows[i].pw) * 10;
      wait_on(0, 1'b1, 4000);
      chk_rng("powerup_timer", 1000 + p, 1012 + p, n);
      wait_on(1, 1'b1, 4000);
      chk_rng("clk_wait", rows[i].lo, rows[i].hi, n);
      chk("cur_osc", 32'(rows[i].osc), 32'(cos));
      bus(1'b0, 32'h0, 32'h0, rd);
      chk("por_flag", 32'h1, rd & 32'h1);
    end
    chk("vector", 32'h0, 32'(vec));
    bus(1'b1, 32'h0, 32'h0, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("rc_clear", 32'h0, rd);
    bus(1'b1, 32'h0, 32'hffffffff, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("rc_set", 32'h000000d3, rd);
    bus(1'b0, 32'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 32'h0, 32'h0, rd);
    // Monitor delay counts from clock ready, so enable it with the soft reset
    bus(1'b1, 32'hc, 32'h3, rd);
    wait_on(2, 1'b1, 3);
    wait_on(2, 1'b0, 3);
    chk_rng("soft_len", 1, 1, n);
    wait_on(3, 1'b1, 3);
    wait_on(4, 1'b1, 1100);
    chk_rng("mon_delay", 995, 1003, n);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("soft_flag", 32'h40, rd & 32'h40);
    bus(1'b0, 32'h4, 32'h0, rd);
    chk("osc_soft", 32'h5000, rd);
    pin_pulse(8'd3);
    repeat (20) @(posedge ref_clk);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("pin_short", 32'h0, rd & 32'h80);
    pin_pulse(8'd12);
    wait_on(2, 1'b1, 20);
    wait_on(3, 1'b1, 40);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("pin_flag", 32'h80, rd & 32'h80);
    bus(1'b0, 32'h4, 32'h0, rd);
    chk("osc_pin", 32'h5000, rd);
    @(posedge ref_clk);
    src[1] <= 1'b1;
    @(posedge ref_clk);
    src[1] <= 1'b0;
    #1 chk("wdt_sys", 32'h1, 32'(sys));
    wait_on(3, 1'b1, 20);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("wdt_flag", 32'h10, rd & 32'h10);
    @(posedge ref_clk);
    slp <= 1'b1;
    pulse(1, 1);
    wait_on(5, 1'b1, 3);
    chk("sleep_sys", 32'h0, 32'(sys));
    @(posedge ref_clk);
    slp <= 1'b0;
    ocw.boot_osc_select <= OSC_FRC;
    pcw.powerup_delay_select <= 3'h0;
    pulse(2, 5);
    repeat (300) @(posedge ref_clk);
    pulse(2, 5);
    wait_on(0, 1'b1, 2000);
    chk_rng("bor_restart", 500, 512, n);
    wait_on(1, 1'b1, 200);
    bus(1'b0, 32'h4, 32'h0, rd);
    chk("osc_cold", 32'h0, rd);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("bor_flag", 32'h2, rd & 32'h2);
    pulse(3, 5);
    wait_on(1, 1'b1, 3000);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk("por_clear", 32'h1, rd & 32'hd1);
    report_and_stop();
  end
endmodule // tb
